// ===== verilog/dual_timer_and_clock_control.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "dtcc_consts.svh"
module dual_timer_and_clock_control
  import dtcc_pkg::*;
#(
  parameter int MACH_CLKS = 4
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic [1:0] modeCode0,
  input  wire logic [1:0] modeCode1,
  input  wire logic       gate0,
  input  wire logic       gate1,
  input  wire logic       counterSel0,
  input  wire logic       counterSel1,
  input  wire logic       firstTimerRun,
  input  wire logic       secondTimerRun,
  input  wire logic       externalInterruptPin0,
  input  wire logic       externalInterruptPin1,
  input  wire logic       firstTimerCountPin,
  input  wire logic       secondTimerCountPin,
  input  wire logic       vectorAck0,
  input  wire logic       vectorAck1,
  input  wire logic       flagWr0,
  input  wire logic       flagWr1,
  input  wire logic       flagWrData0,
  input  wire logic       flagWrData1,
  input  wire logic       moveStart,
  input  wire logic       moveOnChip,
  output logic            firstTimerOverflowFlag,
  output logic            secondTimerOverflowFlag,
  output logic            thirdTimerClockSelect,
  output logic      [1:0] watchdogPeriodCode,
  output wd_count_t       wdIntTimeout,
  output wd_count_t       wdRstTimeout,
  output logic            moveBusy,
  output logic            moveStrobe
);
  typedef struct packed {
    logic [7:0]  low0;
    logic [7:0]  high0;
    logic [7:0]  low1;
    logic [7:0]  high1;
    logic [7:0]  ctl;
    logic        flag0;
    logic        flag1;
    logic [7:0]  rdData;
    wd_count_t   wdInt;
    wd_count_t   wdRst;
    move_state_e mvState;
    logic [3:0]  mvDur;
    logic [3:0]  mvCnt;
    logic [7:0]  mvSub;
    logic        strobe;
  } dtcc_s;
  dtcc_s st_r;
  dtcc_s st_nxt;

  logic       tickFast;
  logic       tickSlow;
  logic [3:0] pinLevel;
  logic [3:0] pinFall;

  prescaler u_pre (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .tickFast (tickFast),
    .tickSlow (tickSlow)
  );

  // pins come from outside the clock domain
  pin_sync #(.W(4)) u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .pinIn    ({secondTimerCountPin, firstTimerCountPin,
                externalInterruptPin1, externalInterruptPin0}),
    .pinLevel (pinLevel),
    .pinFall  (pinFall)
  );

  // returns {overflow, high, low} after one count step
  function automatic logic [16:0] step(input timer_mode_e mode,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [12:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {hi, lo[4:0]} + 13'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    unique case (mode)
      MODE_PRESCALE13: step = {({hi, lo[4:0]} == 13'h1fff),
                               s13[12:5], lo[7:5], s13[4:0]};
      MODE_FULL16:     step = s16;
      MODE_RELOAD8:    step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      MODE_SPLIT:      step = {s8[8], hi, s8[7:0]};
    endcase
  endfunction

  function automatic wd_count_t wdTime(input logic [1:0] code);
    unique case (code)
      2'b00: wdTime = wd_count_t'(1) << `WD_EXP_CODE0;
      2'b01: wdTime = wd_count_t'(1) << `WD_EXP_CODE1;
      2'b10: wdTime = wd_count_t'(1) << `WD_EXP_CODE2;
      2'b11: wdTime = wd_count_t'(1) << `WD_EXP_CODE3;
    endcase
  endfunction

  timer_mode_e mode0;
  timer_mode_e mode1;
  logic        en0;
  logic        en1;
  logic        tick0;
  logic        tick1;
  logic        incLo0;
  logic        incHi0;
  logic        inc1;
  logic [16:0] res0;
  logic [16:0] res1;
  logic [8:0]  resHi0;
  logic        ovf0;
  logic        ovf1;
  logic [3:0]  durSel;

  always_comb begin
    mode0 = timer_mode_e'(modeCode0);
    mode1 = timer_mode_e'(modeCode1);
    en0 = firstTimerRun & (~gate0 | pinLevel[0]);
    en1 = secondTimerRun & (~gate1 | pinLevel[1]);
    tick0 = counterSel0 ? pinFall[2]
                        : (st_r.ctl[`T0_CLK_SEL] ? tickFast : tickSlow);
    tick1 = counterSel1 ? pinFall[3]
                        : (st_r.ctl[`T1_CLK_SEL] ? tickFast : tickSlow);
    incLo0 = en0 & tick0;
    // split high byte ignores the count pin and timer 0 gating
    incHi0 = (mode0 == MODE_SPLIT) & en1 &
             (st_r.ctl[`T0_CLK_SEL] ? tickFast : tickSlow);
    inc1 = en1 & tick1 & (mode1 != MODE_SPLIT);
    res0 = step(mode0, st_r.high0, st_r.low0);
    res1 = step(mode1, st_r.high1, st_r.low1);
    resHi0 = {1'b0, st_r.high0} + 9'h001;
    ovf0 = incLo0 & res0[16];
    // timer 1 loses its flag to the split high byte
    ovf1 = (mode0 == MODE_SPLIT) ? (incHi0 & resHi0[8])
                                 : (inc1 & res1[16]);
    durSel = moveOnChip ? 4'(`MOVE_BASE_MC)
                        : 4'(`MOVE_BASE_MC) + {1'b0, st_r.ctl[`STRETCH_HI:`STRETCH_LO]};
  end

  always_comb begin
    st_nxt = st_r;
    if (incLo0) begin
      st_nxt.low0 = res0[7:0];
      if (mode0 != MODE_SPLIT) begin
        st_nxt.high0 = res0[15:8];
      end
    end
    if (incHi0) begin
      st_nxt.high0 = resHi0[7:0];
    end
    if (inc1) begin
      st_nxt.low1  = res1[7:0];
      st_nxt.high1 = res1[15:8];
    end
    // a software load wins over a count in the same cycle
    if (regWr) begin
      unique case (regAddr)
        `OFS_TIMER0_LOW:  st_nxt.low0  = regWrData;
        `OFS_TIMER1_LOW:  st_nxt.low1  = regWrData;
        `OFS_TIMER0_HIGH: st_nxt.high0 = regWrData;
        `OFS_TIMER1_HIGH: st_nxt.high1 = regWrData;
        `OFS_CLK_STRETCH: st_nxt.ctl   = regWrData;
        default:          st_nxt.ctl   = st_r.ctl;
      endcase
    end
    st_nxt.rdData = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        `OFS_TIMER0_LOW:  st_nxt.rdData = st_r.low0;
        `OFS_TIMER1_LOW:  st_nxt.rdData = st_r.low1;
        `OFS_TIMER0_HIGH: st_nxt.rdData = st_r.high0;
        `OFS_TIMER1_HIGH: st_nxt.rdData = st_r.high1;
        `OFS_CLK_STRETCH: st_nxt.rdData = st_r.ctl;
        default:          st_nxt.rdData = 8'h00;
      endcase
    end
    // hardware set beats any clear in the same cycle
    st_nxt.flag0 = ovf0 | (flagWr0 ? flagWrData0 : (st_r.flag0 & ~vectorAck0));
    st_nxt.flag1 = ovf1 | (flagWr1 ? flagWrData1 : (st_r.flag1 & ~vectorAck1));
    st_nxt.wdInt = wdTime(st_r.ctl[`WD_PERIOD_HI:`WD_PERIOD_LO]);
    st_nxt.wdRst = wdTime(st_r.ctl[`WD_PERIOD_HI:`WD_PERIOD_LO]) + `WD_RST_GAP;
    // move sequencer: busy for dur machine cycles of MACH_CLKS clocks
    unique case (st_r.mvState)
      MV_IDLE: begin
        if (moveStart) begin
          st_nxt.mvState = MV_RUN;
          st_nxt.mvDur   = durSel;
          st_nxt.mvCnt   = durSel - 4'h1;
          st_nxt.mvSub   = 8'(MACH_CLKS - 1);
        end
      end
      MV_RUN: begin
        if (st_r.mvSub != 8'h00) begin
          st_nxt.mvSub = st_r.mvSub - 8'h01;
        end else if (st_r.mvCnt != 4'h0) begin
          st_nxt.mvCnt = st_r.mvCnt - 4'h1;
          st_nxt.mvSub = 8'(MACH_CLKS - 1);
        end else begin
          st_nxt.mvState = MV_IDLE;
        end
      end
    endcase
    // strobe spans all but the address machine cycle, so it grows with N
    st_nxt.strobe = (st_nxt.mvState == MV_RUN) &
                    (st_nxt.mvCnt != st_nxt.mvDur - 4'h1);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r     <= '0;
      st_r.ctl <= `CLK_STRETCH_RST;
      // time-outs match the reset period code at once, so there is no zero window
      st_r.wdInt <= wd_count_t'(1) << `WD_EXP_CODE0;
      st_r.wdRst <= (wd_count_t'(1) << `WD_EXP_CODE0) + `WD_RST_GAP;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData               = st_r.rdData;
  assign firstTimerOverflowFlag  = st_r.flag0;
  assign secondTimerOverflowFlag = st_r.flag1;
  assign thirdTimerClockSelect   = st_r.ctl[`T2_CLK_SEL];
  assign watchdogPeriodCode      = st_r.ctl[`WD_PERIOD_HI:`WD_PERIOD_LO];
  assign wdIntTimeout            = st_r.wdInt;
  assign wdRstTimeout            = st_r.wdRst;
  assign moveBusy                = (st_r.mvState == MV_RUN);
  assign moveStrobe              = st_r.strobe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_stretch_reset: assert property ($fell(srst) |-> st_r.ctl[2:0] == 3'h1 && moveStrobe == 1'b0)
    else $error("stretch field not one after reset");
  a_full16_count: assert property (inc1 && !regWr && mode1 == MODE_FULL16 && mode0 != MODE_SPLIT
                    |=> {st_r.high1, st_r.low1} == $past({st_r.high1, st_r.low1}) + 16'h0001)
    else $error("16-bit count did not advance by one");
  a_reload_low: assert property (inc1 && !regWr && mode1 == MODE_RELOAD8 && st_r.low1 == 8'hff
                    && mode0 != MODE_SPLIT |=> st_r.low1 == $past(st_r.high1) && secondTimerOverflowFlag)
    else $error("low byte not reloaded from high byte");
  a_reload_keep: assert property (mode1 == MODE_RELOAD8 && !regWr
                    |=> st_r.high1 == $past(st_r.high1))
    else $error("reload value changed while counting");
  a_split_hold: assert property (mode1 == MODE_SPLIT && !regWr
                    |=> {st_r.high1, st_r.low1} == $past({st_r.high1, st_r.low1}))
    else $error("timer 1 moved in mode 11");
  a_wd_gap: assert property (wdRstTimeout - wdIntTimeout == 27'h0000200)
    else $error("reset time-out not 512 past interrupt time-out");
  a_wd_period: assert property ($past(watchdogPeriodCode) == 2'b01 && $stable(watchdogPeriodCode)
                    |-> wdIntTimeout == 27'h0100000)
    else $error("watchdog period code 01 not 2^20");
  a_fast_tick: assert property (tickFast |=> !tickFast [*3] ##1 tickFast)
    else $error("fast tick not every fourth clock");
  a_slow_tick: assert property (tickSlow |=> !tickSlow [*8] ##1 !tickSlow [*3] ##1 tickSlow)
    else $error("slow tick not every twelfth clock");
  a_flag_set: assert property (ovf0 |=> firstTimerOverflowFlag)
    else $error("overflow lost to a clear");
  a_vector_clear: assert property (vectorAck0 && !ovf0 && !flagWr0 |=> !firstTimerOverflowFlag)
    else $error("vector did not clear flag");
  a_soft_set: assert property (flagWr1 && flagWrData1 |=> secondTimerOverflowFlag)
    else $error("software could not set flag");
  a_onchip_move: assert property (moveStart && moveOnChip && !moveBusy
                    |=> moveBusy [*8] ##1 !moveBusy)
    else $error("on-chip move not two machine cycles");
  a_short_move: assert property (moveStart && !moveOnChip && !moveBusy && st_r.ctl[2:0] == 3'h0
                    |=> moveBusy [*8] ##1 !moveBusy)
    else $error("stretch zero move not two machine cycles");
  a_strobe_late: assert property ($rose(moveBusy) |-> !moveStrobe [*4] ##1 moveStrobe)
    else $error("strobe not held off for the address cycle");
  a_strobe_inside: assert property (moveStrobe |-> moveBusy)
    else $error("strobe outside a move");
  a_gate_stall: assert property (gate0 && !pinLevel[0] && mode0 == MODE_FULL16 && !regWr
                    |=> {st_r.high0, st_r.low0} == $past({st_r.high0, st_r.low0}))
    else $error("gated timer counted with pin low");
  a_run_stop: assert property (!firstTimerRun && mode0 == MODE_FULL16 && !regWr
                    |=> {st_r.high0, st_r.low0} == $past({st_r.high0, st_r.low0}))
    else $error("stopped timer counted");
  a_pin_count: assert property (counterSel0 && !pinFall[2] && mode0 == MODE_FULL16 && !regWr
                    |=> {st_r.high0, st_r.low0} == $past({st_r.high0, st_r.low0}))
    else $error("counter moved without a pin fall");
  a_prescale_step: assert property (incLo0 && !regWr && mode0 == MODE_PRESCALE13
                    |=> {st_r.high0, st_r.low0[4:0]} == $past({st_r.high0, st_r.low0[4:0]}) + 13'h0001)
    else $error("13-bit count did not advance by one");
  a_prescale_wrap: assert property (incLo0 && !regWr && mode0 == MODE_PRESCALE13
                    && {st_r.high0, st_r.low0[4:0]} == 13'h1fff
                    |=> {st_r.high0, st_r.low0[4:0]} == 13'h0000 && firstTimerOverflowFlag)
    else $error("13-bit wrap did not set flag");
  a_split_low: assert property (incLo0 && !regWr && mode0 == MODE_SPLIT
                    |=> st_r.low0 == $past(st_r.low0) + 8'h01)
    else $error("split low byte did not advance");
  a_split_high: assert property (mode0 == MODE_SPLIT && !secondTimerRun && !regWr
                    |=> st_r.high0 == $past(st_r.high0))
    else $error("split high byte ran without timer 1 run");
  a_split_flag: assert property (incHi0 && st_r.high0 == 8'hff |=> secondTimerOverflowFlag)
    else $error("split high overflow missed timer 1 flag");
  a_clk2_follow: assert property ($past(regWr && regAddr == `OFS_CLK_STRETCH)
                    |-> thirdTimerClockSelect == $past(regWrData[`T2_CLK_SEL]))
    else $error("timer 2 clock select not written");
  a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside the read cycle");
  a_read_low0: assert property (regRd && regAddr == `OFS_TIMER0_LOW |=> regRdData == $past(st_r.low0))
    else $error("timer 0 low byte read wrong");

  c_reload: cover property (inc1 && mode1 == MODE_RELOAD8 && st_r.low1 == 8'hff);
  c_split_ovf: cover property (mode0 == MODE_SPLIT && ovf1);
  c_long_move: cover property (moveBusy && st_r.mvDur == 4'h9 ##1 !moveBusy);
  c_pin_count: cover property (counterSel0 && incLo0);
  c_short_move: cover property (moveStart && !moveOnChip && st_r.ctl[2:0] == 3'h0);
endmodule // dual_timer_and_clock_control

// ===== verilog/dtcc_consts.svh
`ifndef DTCC_CONSTS_SVH
`define DTCC_CONSTS_SVH
// register offsets
`define OFS_TIMER0_LOW   8'h8a
`define OFS_TIMER1_LOW   8'h8b
`define OFS_TIMER0_HIGH  8'h8c
`define OFS_TIMER1_HIGH  8'h8d
`define OFS_CLK_STRETCH  8'h8e
// clock_and_stretch_control fields
`define WD_PERIOD_HI     7
`define WD_PERIOD_LO     6
`define T2_CLK_SEL       5
`define T1_CLK_SEL       4
`define T0_CLK_SEL       3
`define STRETCH_HI       2
`define STRETCH_LO       0
`define CLK_STRETCH_RST  8'h01
// prescale ratios
`define DIV_FAST         4
`define DIV_SLOW         12
// watchdog exponents per period code, reset gap in clocks
`define WD_EXP_CODE0     17
`define WD_EXP_CODE1     20
`define WD_EXP_CODE2     23
`define WD_EXP_CODE3     26
`define WD_RST_GAP       27'h0000200
// external data move length in machine cycles
`define MOVE_BASE_MC     2
`endif

// ===== verilog/dtcc_pkg.sv
package dtcc_pkg;
  typedef enum logic [1:0] {
    MODE_PRESCALE13 = 2'b00,
    MODE_FULL16     = 2'b01,
    MODE_RELOAD8    = 2'b10,
    MODE_SPLIT      = 2'b11
  } timer_mode_e;
  typedef enum logic {
    MV_IDLE = 1'b0,
    MV_RUN  = 1'b1
  } move_state_e;
  typedef logic [26:0] wd_count_t;
endpackage

// ===== verilog/prescaler.sv
`timescale 1ns/1ns
`include "dtcc_consts.svh"
module prescaler (
  input  wire logic ref_clk,
  input  wire logic srst,
  output logic      tickFast,
  output logic      tickSlow
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       fast;
    logic       slow;
  } pre_s;
  pre_s st_r;
  pre_s st_nxt;

  // one shared counter keeps the two tick trains phase aligned
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = (st_r.cnt == 4'(`DIV_SLOW - 1)) ? 4'h0 : st_r.cnt + 4'h1;
    st_nxt.fast = (st_r.cnt[1:0] == 2'(`DIV_FAST - 1));
    st_nxt.slow = (st_r.cnt == 4'(`DIV_SLOW - 1));
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tickFast = st_r.fast;
  assign tickSlow = st_r.slow;
endmodule // prescaler

// ===== verilog/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinLevel,
  output logic      [W-1:0] pinFall
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;

  // edge detect reads only the second and third stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pinIn;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinLevel = st_r.sync;
  assign pinFall  = st_r.prev & ~st_r.sync;
endmodule // pin_sync

// ===== sim/tb.sv
`timescale 1ns/1ns
`include "dtcc_consts.svh"
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin bad_count++; $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module tb;
  import dtcc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [1:0] modeCode0 = 2'h0;
  logic [1:0] modeCode1 = 2'h0;
  logic       gate0 = 1'b0;
  logic       gate1 = 1'b0;
  logic       counterSel0 = 1'b0;
  logic       counterSel1 = 1'b0;
  logic       firstTimerRun = 1'b0;
  logic       secondTimerRun = 1'b0;
  logic       externalInterruptPin0 = 1'b0;
  logic       externalInterruptPin1 = 1'b0;
  logic       firstTimerCountPin = 1'b0;
  logic       secondTimerCountPin = 1'b0;
  logic       vectorAck0 = 1'b0;
  logic       vectorAck1 = 1'b0;
  logic       flagWr0 = 1'b0;
  logic       flagWr1 = 1'b0;
  logic       flagWrData0 = 1'b0;
  logic       flagWrData1 = 1'b0;
  logic       moveStart = 1'b0;
  logic       moveOnChip = 1'b0;
  logic [7:0] regRdData;
  logic       firstTimerOverflowFlag;
  logic       secondTimerOverflowFlag;
  logic       thirdTimerClockSelect;
  logic [1:0] watchdogPeriodCode;
  wd_count_t  wdIntTimeout;
  wd_count_t  wdRstTimeout;
  logic       moveBusy;
  logic       moveStrobe;
  int         bad_count = 0;
  int         n_compared = 0;
  int         n;
  int         s;
  logic [7:0] d;
  logic [7:0] ctrl;
  wd_count_t  ew;

  always #5 ref_clk = ~ref_clk;

  dual_timer_and_clock_control #(.MACH_CLKS(4)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .modeCode0(modeCode0), .modeCode1(modeCode1),
    .gate0(gate0), .gate1(gate1), .counterSel0(counterSel0), .counterSel1(counterSel1),
    .firstTimerRun(firstTimerRun), .secondTimerRun(secondTimerRun),
    .externalInterruptPin0(externalInterruptPin0), .externalInterruptPin1(externalInterruptPin1),
    .firstTimerCountPin(firstTimerCountPin), .secondTimerCountPin(secondTimerCountPin),
    .vectorAck0(vectorAck0), .vectorAck1(vectorAck1), .flagWr0(flagWr0), .flagWr1(flagWr1),
    .flagWrData0(flagWrData0), .flagWrData1(flagWrData1), .moveStart(moveStart), .moveOnChip(moveOnChip),
    .firstTimerOverflowFlag(firstTimerOverflowFlag), .secondTimerOverflowFlag(secondTimerOverflowFlag),
    .thirdTimerClockSelect(thirdTimerClockSelect), .watchdogPeriodCode(watchdogPeriodCode),
    .wdIntTimeout(wdIntTimeout), .wdRstTimeout(wdRstTimeout), .moveBusy(moveBusy), .moveStrobe(moveStrobe)
  );

  task give_verdict;
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task chkRd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
    `CHK("register read", ex, d)
  endtask

  task pulseAck;
    @(posedge ref_clk);
    vectorAck0 <= 1'b1;
    vectorAck1 <= 1'b1;
    @(posedge ref_clk);
    vectorAck0 <= 1'b0;
    vectorAck1 <= 1'b0;
  endtask

  task swFlag(input logic v);
    @(posedge ref_clk);
    flagWr0 <= 1'b1;
    flagWr1 <= 1'b1;
    flagWrData0 <= v;
    flagWrData1 <= v;
    @(posedge ref_clk);
    flagWr0 <= 1'b0;
    flagWr1 <= 1'b0;
    #1;
    `CHK("flag0 by software", v, firstTimerOverflowFlag)
    `CHK("flag1 by software", v, secondTimerOverflowFlag)
  endtask

  task setT(input logic [1:0] m0, input logic [1:0] m1, input logic r0, input logic r1);
    @(posedge ref_clk);
    modeCode0 <= m0;
    modeCode1 <= m1;
    firstTimerRun <= r0;
    secondTimerRun <= r1;
  endtask

  // prescaler phase is free running, so allow up to one tick of slack
  task waitFlag(input logic which, input int lo, input int hi);
    n = 0;
    while (((which ? secondTimerOverflowFlag : firstTimerOverflowFlag) !== 1'b1) && n <= hi) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK("cycles to overflow in range", 1'b1, (n >= lo && n <= hi))
    if (n > hi)
      give_verdict();
  endtask

  task move(input logic onChip, input int dur);
    @(posedge ref_clk);
    moveStart <= 1'b1;
    moveOnChip <= onChip;
    @(posedge ref_clk);
    moveStart <= 1'b0;
    n = 0;
    s = 0;
    #1;
    while (moveBusy === 1'b1 && n < 100) begin
      if (moveStrobe === 1'b1)
        s++;
      n++;
      @(posedge ref_clk);
      #1;
    end
    `CHK("busy cycles", dur * 4, n)
    `CHK("strobe cycles", (dur - 1) * 4, s)
    if (n >= 100)
      give_verdict();
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    chkRd(`OFS_CLK_STRETCH, 8'h01);
    for (int i = 0; i < 4; i++) chkRd(8'(8'h8a + i), 8'h00);
    `CHK("interrupt time-out", 27'h0020000, wdIntTimeout)
    `CHK("reset time-out", 27'h0020200, wdRstTimeout)
    for (int i = 0; i < 4; i++) wr(8'(8'h8a + i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++) chkRd(8'(8'h8a + i), 8'(8'h11 * (i + 1)));
    wr(8'h8f, 8'h5a);
    chkRd(8'h8f, 8'h00);
    chkRd(`OFS_CLK_STRETCH, 8'h01);
    move(1'b0, 3);
    for (int k = 0; k < 8; k++) begin
      wr(`OFS_CLK_STRETCH, 8'(k));
      move(1'b0, k + 2);
    end
    move(1'b1, 2);
    for (int c = 0; c < 4; c++) begin
      ctrl = {2'(c), 1'(c), 5'h01};
      ew = wd_count_t'(1) << (17 + 3 * c);
      wr(`OFS_CLK_STRETCH, ctrl);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK("period code", 2'(c), watchdogPeriodCode)
      `CHK("third clock select", 1'(c), thirdTimerClockSelect)
      `CHK("interrupt time-out", ew, wdIntTimeout)
      `CHK("reset time-out", ew + 27'h0000200, wdRstTimeout)
      chkRd(`OFS_CLK_STRETCH, ctrl);
    end
    // timer 0 on /4, timer 1 on /12
    wr(`OFS_CLK_STRETCH, 8'h09);
    setT(2'b00, 2'b00, 1'b0, 1'b0);
    wr(`OFS_TIMER0_HIGH, 8'hfe);
    wr(`OFS_TIMER0_LOW, 8'hf0);
    pulseAck();
    setT(2'b00, 2'b00, 1'b1, 1'b0);
    waitFlag(1'b0, 47 * 4, 48 * 4 + 3);
    setT(2'b01, 2'b00, 1'b0, 1'b0);
    wr(`OFS_TIMER0_HIGH, 8'hfe);
    wr(`OFS_TIMER0_LOW, 8'hf0);
    pulseAck();
    setT(2'b01, 2'b00, 1'b1, 1'b0);
    waitFlag(1'b0, 271 * 4, 272 * 4 + 3);
    setT(2'b01, 2'b10, 1'b0, 1'b0);
    wr(`OFS_TIMER1_HIGH, 8'hf0);
    wr(`OFS_TIMER1_LOW, 8'hfc);
    pulseAck();
    setT(2'b01, 2'b10, 1'b0, 1'b1);
    waitFlag(1'b1, 3 * 12, 4 * 12 + 3);
    chkRd(`OFS_TIMER1_LOW, 8'hf0);
    pulseAck();
    #1;
    `CHK("flag1 after vector", 1'b0, secondTimerOverflowFlag)
    waitFlag(1'b1, 14 * 12, 16 * 12 + 3);
    setT(2'b00, 2'b11, 1'b0, 1'b0);
    wr(`OFS_TIMER1_LOW, 8'h55);
    setT(2'b00, 2'b11, 1'b0, 1'b1);
    repeat (60) @(posedge ref_clk);
    chkRd(`OFS_TIMER1_LOW, 8'h55);
    setT(2'b00, 2'b01, 1'b0, 1'b0);
    wr(`OFS_TIMER1_HIGH, 8'hff);
    wr(`OFS_TIMER1_LOW, 8'hfe);
    pulseAck();
    setT(2'b00, 2'b01, 1'b0, 1'b1);
    waitFlag(1'b1, 12, 2 * 12 + 3);
    chkRd(`OFS_TIMER1_HIGH, 8'h00);
    setT(2'b11, 2'b00, 1'b0, 1'b0);
    wr(`OFS_TIMER0_LOW, 8'hfe);
    wr(`OFS_TIMER0_HIGH, 8'hfd);
    pulseAck();
    setT(2'b11, 2'b00, 1'b1, 1'b0);
    waitFlag(1'b0, 4, 11);
    setT(2'b11, 2'b00, 1'b0, 1'b1);
    waitFlag(1'b1, 8, 15);
    chkRd(`OFS_TIMER0_LOW, 8'h00);
    setT(2'b01, 2'b00, 1'b0, 1'b0);
    gate0 <= 1'b1;
    wr(`OFS_TIMER0_LOW, 8'h00);
    wr(`OFS_TIMER0_HIGH, 8'h00);
    setT(2'b01, 2'b00, 1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    chkRd(`OFS_TIMER0_LOW, 8'h00);
    // window of 40 enabled clocks holds exactly ten /4 ticks
    @(posedge ref_clk);
    externalInterruptPin0 <= 1'b1;
    repeat (41) @(posedge ref_clk);
    chkRd(`OFS_TIMER0_LOW, 8'h0a);
    setT(2'b01, 2'b00, 1'b0, 1'b0);
    gate0 <= 1'b0;
    counterSel0 <= 1'b1;
    firstTimerCountPin <= 1'b1;
    wr(`OFS_TIMER0_HIGH, 8'hff);
    wr(`OFS_TIMER0_LOW, 8'hfd);
    pulseAck();
    setT(2'b01, 2'b00, 1'b1, 1'b0);
    for (int p = 0; p < 3; p++) begin
      repeat (4) @(posedge ref_clk);
      firstTimerCountPin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      firstTimerCountPin <= 1'b1;
      if (p == 1)
        chkRd(`OFS_TIMER0_LOW, 8'hff);
    end
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("flag0 after pin falls", 1'b1, firstTimerOverflowFlag)
    setT(2'b00, 2'b00, 1'b0, 1'b0);
    swFlag(1'b0);
    swFlag(1'b1);
    give_verdict();
  end
endmodule // tb
